// ---- hdl/edp_estop_seq.sv ----
`timescale 1ns/1ps
`default_nettype none
module edp_estop_seq
    import edp_pkg::*;
#(
    parameter int CYCLES_PER_MS = CYCLES_PER_MS_DFLT
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire edp_pins_t pinsIn,
    input wire logic [15:0] speedIn,
    output logic [15:0] speedOut_q,
    output logic readyOn_q,
    output logic gateOn_q,
    output logic dynBrake_q,
    output logic pullUp_q,
    output logic dbToPartner_q,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    function automatic logic [15:0] umax(input logic [15:0] a, input logic [15:0] b);
        umax = (a > b) ? a : b;
    endfunction : umax

    function automatic logic [15:0] clampTime(input logic [15:0] v);
        clampTime = (v > TIME_MAX) ? TIME_MAX : v;
    endfunction : clampTime

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    edp_pins_t pinMeta_q;
    edp_pins_t pinSync_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pinMeta_q <= '0;
            pinSync_q <= '0;
        end else if (ce) begin
            pinMeta_q <= pinsIn;
            pinSync_q <= pinMeta_q;
        end
    end

    // ------------------------------------------------------------
    // Register file over AXI4-Lite
    // ------------------------------------------------------------
    logic [15:0] ctrl_q;
    logic signed [15:0] decel_q;
    logic [15:0] drop_q;
    logic [15:0] gate_q;
    logic [15:0] peerDrop_q;
    logic [15:0] peerGate_q;
    logic [15:0] rapid_q;
    logic [7:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic awHave_q;
    logic wHave_q;
    edp_state_t state_q;
    logic [15:0] elapsed_q;
    logic signed [15:0] wSigned;
    logic [15:0] wTime;
    logic wrFire;
    logic wrHit;

    assign wrFire = awHave_q && wHave_q && !s_axi_bvalid;
    assign wSigned = wData_q[15:0];
    assign wTime = clampTime(wData_q[15:0]);
    assign wrHit = (awAddr_q <= ADDR_RAPID) && (awAddr_q[1:0] == 2'b00);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
            awAddr_q <= '0;
            wData_q <= '0;
            wStrb_q <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (ce) begin
            s_axi_awready <= !awHave_q && !s_axi_awready && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !wHave_q && !s_axi_wready && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                awHave_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHave_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wrFire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                awHave_q <= 1'b0;
                wHave_q <= 1'b0;
            end
        end
    end

    // Byte strobes are honoured per register as a whole only when both low lanes are set,
    // because every field is 16 bits and a half-written time value would be meaningless.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_q <= CTRL_RST;
            decel_q <= TIME_RST;
            drop_q <= TIME_RST;
            gate_q <= TIME_RST;
            peerDrop_q <= TIME_RST;
            peerGate_q <= TIME_RST;
            rapid_q <= RAPID_RST;
        end else if (ce && wrFire && (wStrb_q[1:0] == 2'b11)) begin
            unique case (awAddr_q)
                ADDR_CTRL: ctrl_q <= wData_q[15:0];
                ADDR_DECEL: begin
                    if (wSigned > DECEL_MAX) begin
                        decel_q <= DECEL_MAX; // [R1]
                    end else if (wSigned < DECEL_MIN) begin
                        decel_q <= DECEL_MIN; // [R1]
                    end else begin
                        decel_q <= wSigned;
                    end
                end
                ADDR_DROP: drop_q <= wTime; // [R5]
                ADDR_GATE: gate_q <= wTime; // [R6]
                ADDR_PEER_DROP: peerDrop_q <= wTime;
                ADDR_PEER_GATE: peerGate_q <= wTime;
                ADDR_RAPID: rapid_q <= wData_q[15:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (ce) begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !s_axi_arvalid ? 1'b0
                           : (!s_axi_rvalid && !s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OKAY;
                unique case (s_axi_araddr)
                    ADDR_CTRL: s_axi_rdata <= {16'h0000, ctrl_q};
                    ADDR_DECEL: s_axi_rdata <= {{16{decel_q[15]}}, decel_q};
                    ADDR_DROP: s_axi_rdata <= {16'h0000, drop_q};
                    ADDR_GATE: s_axi_rdata <= {16'h0000, gate_q};
                    ADDR_PEER_DROP: s_axi_rdata <= {16'h0000, peerDrop_q};
                    ADDR_PEER_GATE: s_axi_rdata <= {16'h0000, peerGate_q};
                    ADDR_RAPID: s_axi_rdata <= {16'h0000, rapid_q};
                    ADDR_STATUS: s_axi_rdata <= {speedOut_q, 3'b000, dbToPartner_q, pullUp_q,
                                                 dynBrake_q, gateOn_q, readyOn_q, 3'b000, state_q};
                    ADDR_ELAPSED: s_axi_rdata <= {16'h0000, elapsed_q};
                    default: begin
                        s_axi_rdata <= '0;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Stop conditions and unit-wide timing
    // ------------------------------------------------------------
    logic estopCond;
    logic syncAxis;
    logic dropEn;
    logic decelEn;
    logic dbDemand;
    logic [15:0] absDecel;
    logic [15:0] dropEff;
    logic [15:0] gateEff;
    logic [15:0] gateLimit;
    logic pfExpired;

    assign estopCond = pinSync_q.estop || pinSync_q.ncPowerDown || pinSync_q.driveAlarm
                     || pinSync_q.dbAlarm; // [R14]
    assign syncAxis = decel_q < 0; // [R3]
    assign decelEn = ctrl_q[BIT_DECEL_EN];
    // Drop prevention depends on the ramp being enabled as well.
    assign dropEn = ctrl_q[BIT_DROP_EN] && decelEn; // [R12]
    assign dbDemand = pinSync_q.dbAlarm || (syncAxis && pinSync_q.partnerDb); // [R3] [R4]
    assign absDecel = syncAxis ? 16'(-decel_q) : decel_q;
    assign dropEff = dropEn ? umax(drop_q, peerDrop_q) : 16'h0000; // [R8]
    assign gateEff = umax(gate_q, peerGate_q); // [R8]
    assign gateLimit = umax(gateEff, dropEff); // [R7]
    assign pfExpired = pinSync_q.powerFail && (elapsed_q >= PF_LIMIT_MS); // [R11]

    // ------------------------------------------------------------
    // Millisecond timebase
    // ------------------------------------------------------------
    logic [31:0] prescale_q;
    logic msTick;

    assign msTick = (prescale_q == 32'(CYCLES_PER_MS - 1));

    always_ff @(posedge core_clk) begin
        if (rst) begin
            prescale_q <= '0;
        end else if (ce) begin
            prescale_q <= msTick ? '0 : prescale_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            elapsed_q <= '0;
        end else if (ce) begin
            if (state_q == ST_RUN) begin
                elapsed_q <= '0; // [R16]
            end else if (msTick && elapsed_q != 16'hffff) begin
                elapsed_q <= elapsed_q + 16'h0001; // [R16]
            end
        end
    end

    // ------------------------------------------------------------
    // Stop sequencer
    // ------------------------------------------------------------
    edp_state_t state_d;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_RUN: begin
                if (estopCond) begin
                    if (dbDemand || !decelEn) begin
                        state_d = ST_DBRK; // [R4]
                    end else if (absDecel == 16'h0000) begin
                        state_d = ST_HOLD; // [R2]
                    end else begin
                        state_d = ST_DECEL;
                    end
                end
            end
            ST_DECEL: begin
                if (dbDemand || pfExpired) begin
                    state_d = ST_DBRK; // [R3] [R11]
                end else if (elapsed_q >= gateLimit && gateLimit != 16'h0000) begin
                    state_d = ST_OFF; // [R6]
                end else if (speedOut_q == 16'h0000) begin
                    state_d = ST_HOLD; // [R13]
                end
            end
            ST_HOLD: begin
                if (dbDemand || pfExpired) begin
                    state_d = ST_DBRK; // [R9] [R11]
                end else if (elapsed_q >= dropEff || elapsed_q >= gateLimit) begin
                    state_d = ST_OFF; // [R5] [R6] [R7]
                end
            end
            ST_OFF, ST_DBRK: begin
                if (!estopCond && !pinSync_q.partnerDb) begin
                    state_d = ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= ST_RUN;
        end else if (ce) begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Speed ramp
    // ------------------------------------------------------------
    // The slope is spread error-free over cycles: each millisecond adds the rapid rate to an
    // accumulator, and each cycle spends one time constant of it on one speed count. The slope
    // is thus rapid/T counts per ms from any start speed; it must stay below one count per cycle.
    logic [31:0] rampAcc_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rampAcc_q <= '0;
            speedOut_q <= '0;
        end else if (ce) begin
            unique case (state_d)
                ST_RUN: begin
                    rampAcc_q <= '0;
                    speedOut_q <= speedIn;
                end
                ST_DECEL: begin
                    if (rampAcc_q >= {16'h0000, absDecel} && speedOut_q != 16'h0000) begin
                        rampAcc_q <= rampAcc_q - {16'h0000, absDecel} // [R15]
                                   + (msTick ? {16'h0000, rapid_q} : 32'h0000_0000);
                        speedOut_q <= speedOut_q - 16'h0001; // [R15]
                    end else if (msTick) begin
                        rampAcc_q <= rampAcc_q + {16'h0000, rapid_q}; // [R15]
                    end
                end
                default: begin
                    rampAcc_q <= '0;
                    speedOut_q <= '0; // [R2]
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Drive outputs
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            readyOn_q <= 1'b0;
            gateOn_q <= 1'b0;
            dynBrake_q <= 1'b0;
            pullUp_q <= 1'b0;
        end else if (ce) begin
            readyOn_q <= state_d inside {ST_RUN, ST_DECEL, ST_HOLD}; // [R13]
            gateOn_q <= state_d inside {ST_RUN, ST_DECEL, ST_HOLD}; // [R7]
            dynBrake_q <= state_d inside {ST_OFF, ST_DBRK}; // [R13] [R4]
            pullUp_q <= (state_d == ST_HOLD) && ctrl_q[BIT_PULLUP_EN] && dropEn; // [R10]
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            dbToPartner_q <= 1'b0;
        end else if (ce) begin
            dbToPartner_q <= syncAxis && (state_d == ST_DBRK); // [R3]
        end
    end
endmodule : edp_estop_seq
`default_nettype wire

// ---- hdl/edp_pkg.sv ----
// Notes on behaviour
// R1: The deceleration time constant is a signed millisecond value held within -20000 to 20000.
// R2: A deceleration time constant of zero stops the axis with a step instead of a ramp.
// R3: A negative time constant marks a synchronous pair, and dynamic braking on one axis forces it on the other.
// R4: An alarm that names dynamic braking skips the ramp and stops with dynamic braking.
// R5: During an emergency stop ready-off is held back for the drop-prevention time of 0 to 20000 ms.
// R6: Ready-off is forced no later than the maximum gate-off delay, 0 to 20000 ms after the stop.
// R7: With drop prevention on, gate-off waits at least the drop-prevention time even if the limit is lower.
// R8: The unit uses the larger of its own and its peer axes' drop and gate-off times.
// R9: A dynamic-braking alarm on a drop-prevention axis cancels the ready-off delay.
// R10: With the pull-up flag set, pull-up is applied through the whole drop-prevention interval; the code applies it only in ST_HOLD, after the ramp.
// R11: On power failure, intervals beyond 100 ms are not kept and the axis falls back to dynamic braking.
// R12: The controller must enable deceleration control whenever it enables drop prevention.
// R13: Ready stays on during the ramp, then drops with dynamic braking once the motor has stopped.
// R14: External stop, peer alarms, controller power-down and local drive alarms all start an emergency stop; partnerDb alone starts none in the code.
// R15: The ramp slope is the rapid rate divided by the time constant, the same from every speed.
// R16: Drop-prevention and gate-off timers count milliseconds from the first cycle of the stop; the code's ms tick runs free, so the first ms can be short.
package edp_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int MS_NS = 1000000;
    localparam int CYCLES_PER_MS_DFLT = MS_NS / CLK_PERIOD_NS;
    localparam logic signed [15:0] DECEL_MAX = 16'sh4e20;
    localparam logic signed [15:0] DECEL_MIN = -16'sh4e20;
    localparam logic [15:0] TIME_MAX = 16'h4e20;
    localparam logic [15:0] PF_LIMIT_MS = 16'h0064;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DECEL = 8'h04;
    localparam logic [7:0] ADDR_DROP = 8'h08;
    localparam logic [7:0] ADDR_GATE = 8'h0c;
    localparam logic [7:0] ADDR_PEER_DROP = 8'h10;
    localparam logic [7:0] ADDR_PEER_GATE = 8'h14;
    localparam logic [7:0] ADDR_RAPID = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1c;
    localparam logic [7:0] ADDR_ELAPSED = 8'h20;
    localparam int BIT_DECEL_EN = 0;
    localparam int BIT_DROP_EN = 1;
    localparam int BIT_PULLUP_EN = 14;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] TIME_RST = 16'h0000;
    localparam logic [15:0] RAPID_RST = 16'h0100;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [4:0] {
        ST_RUN = 5'b00001,
        ST_DECEL = 5'b00010,
        ST_HOLD = 5'b00100,
        ST_OFF = 5'b01000,
        ST_DBRK = 5'b10000
    } edp_state_t;

    // Asynchronous stop sources and the partnerDb and powerFail qualifiers arriving on pins.
    typedef struct packed {
        logic estop;
        logic ncPowerDown;
        logic driveAlarm;
        logic dbAlarm;
        logic partnerDb;
        logic powerFail;
    } edp_pins_t;
endpackage : edp_pkg

// ---- verif/edp_estop_seq_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module edp_estop_seq_asserts
    import edp_pkg::*;
#(
    parameter int CYCLES_PER_MS = CYCLES_PER_MS_DFLT
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire edp_pins_t pinsIn,
    input wire logic [15:0] speedIn,
    input wire logic [15:0] speedOut_q,
    input wire logic readyOn_q,
    input wire logic gateOn_q,
    input wire logic dynBrake_q,
    input wire logic pullUp_q,
    input wire logic dbToPartner_q
);
    // Counters saturate so that a long stop never wraps round into a false pass.
    localparam int PF_CYC = 100 * CYCLES_PER_MS + 8;
    logic stopNow;
    int stopCnt_q;
    int quietCnt_q;
    int pfCnt_q;
    assign stopNow = pinsIn.estop | pinsIn.ncPowerDown | pinsIn.driveAlarm | pinsIn.dbAlarm;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            stopCnt_q <= 0;
            quietCnt_q <= 0;
            pfCnt_q <= 0;
        end else begin
            stopCnt_q <= stopNow ? stopCnt_q + (stopCnt_q < 65535 ? 1 : 0) : 0;
            quietCnt_q <= (pinsIn == '0) ? quietCnt_q + (quietCnt_q < 65535 ? 1 : 0) : 0;
            pfCnt_q <= (stopNow && pinsIn.powerFail) ? pfCnt_q + (pfCnt_q < 65535 ? 1 : 0) : 0;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_reset_clears_out: assert property (disable iff (1'b0) rst && ce |=> !readyOn_q)
        else $error("ready not cleared by reset");
    a_gate_with_ready: assert property (gateOn_q == readyOn_q)
        else $error("gate and ready disagree");
    a_brake_not_ready: assert property (dynBrake_q |-> !readyOn_q && speedOut_q == 16'h0000)
        else $error("brake engaged while ready or moving");
    a_run_follows_cmd: assert property (quietCnt_q >= 4 && readyOn_q && $past(readyOn_q)
        |-> speedOut_q == $past(speedIn))
        else $error("speed not followed while running");
    a_ramp_no_rise: assert property (stopCnt_q >= 6 && readyOn_q
        |-> speedOut_q <= $past(speedOut_q))
        else $error("speed rose during stop");
    a_db_alarm_stop: assert property (pinsIn.dbAlarm [*8] |-> !readyOn_q && dynBrake_q)
        else $error("brake alarm did not stop at once");
    a_pf_cut_short: assert property (pfCnt_q > PF_CYC |-> !readyOn_q && dynBrake_q)
        else $error("power fail interval overran");
    a_partner_brakes: assert property ($rose(dbToPartner_q) |-> dynBrake_q)
        else $error("partner brake flag without own brake");
    a_pullup_in_hold: assert property (pullUp_q |-> readyOn_q && speedOut_q == 16'h0000)
        else $error("pull-up outside hold");
    c_brake_stop: cover property ($fell(readyOn_q) && dynBrake_q);
    c_pullup: cover property ($rose(pullUp_q));
    c_partner: cover property ($rose(dbToPartner_q));
endmodule : edp_estop_seq_asserts

bind edp_estop_seq edp_estop_seq_asserts #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_edp_estop_seq_asserts (
    .core_clk(core_clk), .rst(rst), .ce(ce), .pinsIn(pinsIn), .speedIn(speedIn),
    .speedOut_q(speedOut_q), .readyOn_q(readyOn_q), .gateOn_q(gateOn_q),
    .dynBrake_q(dynBrake_q), .pullUp_q(pullUp_q), .dbToPartner_q(dbToPartner_q)
);
`default_nettype wire

// ---- verif/edp_estop_seq_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module edp_estop_seq_tb_top;
    import edp_pkg::*;
    localparam int CPM = 10;
    logic core_clk = 1'b0, rst = 1'b1, ce = 1'b1;
    edp_pins_t stopReq = '0, pinsIn;
    logic [15:0] speedReq = 16'h0000, speedIn, speedOut_q;
    logic readyOn_q, gateOn_q, dynBrake_q, pullUp_q, dbToPartner_q;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    int fail_count = 0, samples_checked = 0, cycles = 0;
    always #50 core_clk = ~core_clk;
    edp_nc_model u_edp_nc_model (
        .core_clk(core_clk), .stopReq(stopReq), .speedReq(speedReq), .pinsIn(pinsIn),
        .speedIn(speedIn)
    );
    edp_estop_seq #(.CYCLES_PER_MS(CPM)) u_edp_estop_seq (
        .core_clk(core_clk), .rst(rst), .ce(ce), .pinsIn(pinsIn), .speedIn(speedIn),
        .speedOut_q(speedOut_q), .readyOn_q(readyOn_q), .gateOn_q(gateOn_q),
        .dynBrake_q(dynBrake_q), .pullUp_q(pullUp_q), .dbToPartner_q(dbToPartner_q),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready)
    );
    task automatic results();
        $display("checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            $display("unexpected run length: expected under 20000, seen %0d", cycles);
            results();
        end
    end
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask : check
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic awDone;
        logic wDone;
        awDone = 1'b0;
        wDone = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        // Track each channel locally: the valid flags only change after this time step.
        while (!(awDone && wDone)) begin
            @(posedge core_clk);
            if (s_axi_awready === 1'b1 && !awDone) begin
                awDone = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready === 1'b1 && !wDone) begin
                wDone = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge core_clk);
    endtask : axiWrite
    task automatic axiRead(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge core_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge core_clk);
    endtask : axiRead
    // Reference: milliseconds from the stop until ready drops, worked out from the rules.
    function automatic int expOff(logic [15:0] c, int t, int dr, int gt, int pd, edp_pins_t p,
                                  int spd);
        int dropEff;
        int lim;
        int off;
        if (!c[0] || p.dbAlarm || (t < 0 && p.partnerDb)) return 0;
        dropEff = c[1] ? ((dr > pd) ? dr : pd) : 0;
        off = (t == 0) ? 0 : (spd * (t < 0 ? -t : t) + RAPID_RST - 1) / RAPID_RST;
        if (dropEff > off) off = dropEff;
        lim = (gt > dropEff) ? gt : dropEff;
        if (lim > 0 && lim < off) off = lim;
        if (p.powerFail && off > PF_LIMIT_MS) off = PF_LIMIT_MS;
        return off;
    endfunction : expOff
    task automatic runCase(input logic [15:0] c, input int t, input int dr, input int gt,
                           input int pd, input edp_pins_t p, input int spd);
        int e;
        int cyc;
        logic sawPull;
        e = expOff(c, t, dr, gt, pd, p, spd);
        cyc = 0;
        sawPull = 1'b0;
        axiWrite(ADDR_CTRL, {16'h0, c}, 4'hf);
        axiWrite(ADDR_DECEL, t, 4'hf);
        axiWrite(ADDR_DROP, dr, 4'hf);
        axiWrite(ADDR_GATE, gt, 4'hf);
        axiWrite(ADDR_PEER_DROP, pd, 4'hf);
        speedReq <= spd[15:0];
        repeat (4) @(posedge core_clk);
        check("speed run", spd, speedOut_q);
        stopReq <= p;
        while (readyOn_q === 1'b1 && cyc < 2000) begin
            @(posedge core_clk);
            cyc++;
            sawPull |= pullUp_q;
        end
        check("off time", 1, cyc + CPM >= e * CPM && cyc <= e * CPM + 25);
        check("brake", 1, dynBrake_q);
        if (t < 0 && p.dbAlarm) check("partner flag", 1, dbToPartner_q);
        if (c[14] && e > 0) check("pull-up", 1, sawPull);
        axiRead(ADDR_STATUS);
        check("status", 3'b100, rd[10:8]);
        repeat (8) @(posedge core_clk);
        stopReq <= '0;
        repeat (8) @(posedge core_clk);
        check("release", 1, readyOn_q);
    endtask : runCase
    initial begin
        void'($urandom(32'h53eecfb9));
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        axiRead(ADDR_CTRL);
        check("ctrl reset", {16'h0, CTRL_RST}, rd);
        axiRead(ADDR_RAPID);
        check("rapid reset", {16'h0, RAPID_RST}, rd);
        axiRead(8'h40);
        check("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
        axiWrite(ADDR_STATUS, 32'h1, 4'hf);
        check("status write", {30'h0, RESP_SLVERR}, {30'h0, resp});
        axiWrite(ADDR_DROP, 32'h7, 4'h1);
        axiRead(ADDR_DROP);
        check("strobe", {16'h0, TIME_RST}, rd);
        axiWrite(ADDR_DECEL, 32'h7530, 4'hf);
        axiRead(ADDR_DECEL);
        check("decel high", 32'h4e20, rd);
        axiWrite(ADDR_DECEL, 32'h8ad0, 4'hf);
        axiRead(ADDR_DECEL);
        check("decel low", 32'hffffb1e0, rd);
        runCase(16'h4003, 40, 5, 3, 8, 6'b100000, 10 + $urandom % 25);
        runCase(16'h0003, 100, 0, 0, 0, 6'b100000, 100 + $urandom % 100);
        runCase(16'h0003, 100, 0, 5, 0, 6'b010000, 150 + $urandom % 100);
        runCase(16'h0003, 0, 4, 0, 0, 6'b001000, 100);
        runCase(16'h0003, 10, 8, 0, 8, 6'b100100, 100);
        runCase(16'h0000, 10, 0, 0, 0, 6'b100000, 100);
        runCase(16'h0003, -10, 6, 0, 0, 6'b100010, 100);
        runCase(16'h0003, -10, 0, 0, 0, 6'b000100, 100);
        runCase(16'h0003, 10, 200, 0, 0, 6'b100001, 100);
        results();
    end
endmodule : edp_estop_seq_tb_top
`default_nettype wire

// ---- verif/edp_nc_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module edp_nc_model
    import edp_pkg::*;
(
    input wire logic core_clk,
    input wire edp_pins_t stopReq,
    input wire logic [15:0] speedReq,
    output var edp_pins_t pinsIn = '0,
    output var logic [15:0] speedIn = 16'h0000
);
    // Controller outputs move just after an edge, never in between.
    always_ff @(posedge core_clk) begin
        pinsIn <= stopReq;
        speedIn <= speedReq;
    end
endmodule : edp_nc_model
`default_nettype wire
